/* hw/ots_pkg.sv */
// Constants, register map and shared types for the oscillator trim and spread block
package ots_pkg;

	// ==========================================================
	// Bus widths
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// ==========================================================
	// Register map
	localparam logic [15:0] MAIN_REG_TRIM_ADDR = 16'ha000;
	localparam logic [15:0] OSC_COARSE_TRIM_SPREAD_ADDR = 16'ha001;
	localparam logic [15:0] OSC_FINE_TRIM_ADDR = 16'ha002;

	// ==========================================================
	// Reset values
	localparam logic [7:0] MAIN_REG_TRIM_RST = 8'hff;
	localparam logic [7:0] OSC_COARSE_TRIM_SPREAD_RST = 8'h00;
	localparam logic [7:0] OSC_FINE_TRIM_RST = 8'h8e;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ==========================================================
	// Fields of the coarse trim and spread register
	localparam int unsigned RATE_HI = 7;
	localparam int unsigned RATE_LO = 4;
	localparam int unsigned AMP_HI = 3;
	localparam int unsigned AMP_LO = 2;
	localparam int unsigned RANGE_HI = 1;
	localparam int unsigned RANGE_LO = 0;

	// ==========================================================
	// Sweep amplitude codes and their peak deviation
	localparam logic [1:0] AMP_CODE_4 = 2'h0;
	localparam logic [1:0] AMP_CODE_8 = 2'h1;
	localparam logic [1:0] AMP_CODE_16 = 2'h2;
	localparam logic [1:0] AMP_CODE_32 = 2'h3;
	localparam int unsigned OFS_W = 7;
	localparam logic signed [6:0] DEV_4 = 7'sh04;
	localparam logic signed [6:0] DEV_8 = 7'sh08;
	localparam logic signed [6:0] DEV_16 = 7'sh10;
	localparam logic signed [6:0] DEV_32 = 7'sh20;
	localparam logic signed [6:0] OFS_ZERO = 7'sh00;
	localparam logic signed [6:0] OFS_STEP = 7'sh01;
	localparam logic [3:0] RATE_OFF = 4'h0;
	localparam logic [3:0] RATE_ONE = 4'h1;
	localparam logic [3:0] CNT_ZERO = 4'h0;

	// ==========================================================
	// Clamp bounds of the oscillator control code
	localparam logic signed [9:0] TRIM_CLAMP_MIN = 10'sh000;
	localparam logic signed [9:0] TRIM_CLAMP_MAX = 10'sh0ff;

	// ==========================================================
	// Power modes and sweep direction states
	typedef enum logic [2:0] {
		PM_NORMAL = 3'h0,
		PM_PMM = 3'h1,
		PM_IDLE = 3'h2,
		PM_STOP = 3'h3,
		PM_SLEEP = 3'h4
	} ots_pmode_e;

	typedef enum logic [1:0] {
		SW_HOLD = 2'h0,
		SW_UP = 2'h1,
		SW_DOWN = 2'h3
	} ots_sweep_e;

endpackage

/* hw/ots_sweep_gen.sv */
// Triangular sweep offset generator for the oscillator fine trim
`timescale 1ns/1ps
module ots_sweep_gen
	import ots_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [3:0] sweepRateCode,
	input wire logic [1:0] sweepAmplitudeCode,
	output logic signed [6:0] sweepOfs
);

	ots_sweep_e state_r, state_nxt;
	logic signed [6:0] ofs_r, ofs_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic signed [6:0] dev;
	logic spreadOn;
	logic tick;

	// ==========================================================
	// Next state
	always_comb begin
		case (sweepAmplitudeCode)
			AMP_CODE_32: dev = DEV_32; // RL11
			AMP_CODE_16: dev = DEV_16; // RL11
			AMP_CODE_8: dev = DEV_8; // RL11
			default: dev = DEV_4; // RL11
		endcase
		spreadOn = sweepRateCode != RATE_OFF; // RL10
		// >= so a rate lowered to or below the count ends the current wait at once
		tick = cnt_r >= (sweepRateCode - RATE_ONE); // RL14 RL15 RL18
		state_nxt = state_r;
		ofs_nxt = ofs_r;
		cnt_nxt = tick ? CNT_ZERO : cnt_r + RATE_ONE;
		if (!spreadOn) begin
			state_nxt = SW_HOLD; // RL17
			ofs_nxt = OFS_ZERO; // RL17
			cnt_nxt = CNT_ZERO;
		end else if (tick) begin
			case (state_r)
				SW_UP: begin
					// Past a shrunken peak it walks back one step at a time
					if (ofs_r >= dev) begin
						state_nxt = SW_DOWN; // RL17
						ofs_nxt = ofs_r - OFS_STEP; // RL17 RL18
					end else begin
						ofs_nxt = ofs_r + OFS_STEP; // RL17
					end
				end
				SW_DOWN: begin
					if (ofs_r <= -dev) begin
						state_nxt = SW_UP; // RL17
						ofs_nxt = ofs_r + OFS_STEP; // RL17 RL18
					end else begin
						ofs_nxt = ofs_r - OFS_STEP; // RL17
					end
				end
				default: begin
					state_nxt = SW_UP;
					ofs_nxt = ofs_r + OFS_STEP; // RL17
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= SW_HOLD;
			ofs_r <= OFS_ZERO;
			cnt_r <= CNT_ZERO;
		end else if (clkEn) begin
			state_r <= state_nxt;
			ofs_r <= ofs_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign sweepOfs = ofs_r;

endmodule // ots_sweep_gen

/* hw/ots_analog_ctrl.sv */
// Trim registers, power gating and spread-spectrum control for the analog support blocks
`timescale 1ns/1ps

// ==========================================================
// Overview
// Software trims the main regulator and the internal
// oscillator through three byte registers. The power mode
// input decides which analog blocks are powered. A sweep
// generator moves the fine trim in a triangle when spread
// spectrum is selected.

// Behaviour
// [RL1] Main regulator on except SLEEP; backup then
// [RL2] Main regulator enable on after reset
// [RL3] Regulator trim resets to ff, read/write
// [RL4] Regulator trim passes to regulator unchanged
// [RL5] Voltage reference on only in normal mode
// [RL6] Oscillator enabled except in STOP mode
// [RL7] Oscillator gating without glitches or extra edges
// [RL8] Oscillator trims return to defaults on reset
// [RL9] Coarse register: rate, amplitude, range fields
// [RL10] Rate code zero disables spreading
// [RL11] Amplitude code selects deviation 4/8/16/32
// [RL12] Output is fine trim plus sweep offset
// [RL13] Coarse range code drives oscillator directly
// [RL14] Sweep steps once every rate-code cycles
// [RL15] Full sweep period follows rate and deviation
// [RL16] Modulated code clamped to 0..255
// [RL17] Triangle steps by one, zero when off
// [RL18] Code changes apply at next update, glitch-free
module ots_analog_ctrl
	import ots_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [2:0] powerMode,
	input wire logic [15:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [7:0] rdData,
	output logic [7:0] mainRegulatorTrim,
	output logic mainRegEn,
	output logic backupRegEn,
	output logic refEn,
	output logic oscEn,
	output logic [1:0] coarseRangeCode,
	output logic [7:0] modulatedTrimOutput
);

	// ==========================================================
	// Declarations
	logic [7:0] mainRegulatorTrim_r, mainRegulatorTrim_nxt;
	logic [7:0] oscCoarseTrimSpread_r, oscCoarseTrimSpread_nxt;
	logic [7:0] oscFineTrim_r, oscFineTrim_nxt;
	logic [7:0] rdData_r, rdData_nxt;

	logic mainRegEn_r, mainRegEn_nxt;
	logic backupRegEn_r, backupRegEn_nxt;
	logic refEn_r, refEn_nxt;
	logic oscEn_r, oscEn_nxt;

	logic [1:0] coarseRange_r, coarseRange_nxt;
	logic [7:0] modTrim_r, modTrim_nxt;

	logic [3:0] sweepRateCode;
	logic [1:0] sweepAmplitudeCode;
	logic [1:0] coarseRangeField;
	logic signed [6:0] sweepOfs;
	logic signed [9:0] trimSum;

	logic hitMainTrim;
	logic hitCoarse;
	logic hitFine;

	ots_pmode_e mode;

	// ==========================================================
	// Field split of the coarse trim and spread register
	assign sweepRateCode = oscCoarseTrimSpread_r[RATE_HI:RATE_LO]; // RL9
	assign sweepAmplitudeCode = oscCoarseTrimSpread_r[AMP_HI:AMP_LO]; // RL9
	assign coarseRangeField = oscCoarseTrimSpread_r[RANGE_HI:RANGE_LO]; // RL9

	// Unknown codes fall back to normal mode below
	assign mode = ots_pmode_e'(powerMode);

	// ==========================================================
	// Address decode
	assign hitMainTrim = addr == MAIN_REG_TRIM_ADDR;
	assign hitCoarse = addr == OSC_COARSE_TRIM_SPREAD_ADDR;
	assign hitFine = addr == OSC_FINE_TRIM_ADDR;

	// ==========================================================
	// Register writes
	always_comb begin
		mainRegulatorTrim_nxt = mainRegulatorTrim_r;
		oscCoarseTrimSpread_nxt = oscCoarseTrimSpread_r;
		oscFineTrim_nxt = oscFineTrim_r;
		if (wrEn) begin
			if (hitMainTrim) begin
				mainRegulatorTrim_nxt = wrData; // RL3
			end
			if (hitCoarse) begin
				// Fields land together; the sweep sees them on its next update
				oscCoarseTrimSpread_nxt = wrData; // RL9 RL18
			end
			if (hitFine) begin
				oscFineTrim_nxt = wrData;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mainRegulatorTrim_r <= MAIN_REG_TRIM_RST; // RL3
			oscCoarseTrimSpread_r <= OSC_COARSE_TRIM_SPREAD_RST; // RL8 RL9
			oscFineTrim_r <= OSC_FINE_TRIM_RST; // RL8
		end else if (clkEn) begin
			mainRegulatorTrim_r <= mainRegulatorTrim_nxt;
			oscCoarseTrimSpread_r <= oscCoarseTrimSpread_nxt;
			oscFineTrim_r <= oscFineTrim_nxt;
		end
	end

	// ==========================================================
	// Register reads
	// Data stand for exactly one cycle after the strobe
	always_comb begin
		rdData_nxt = READ_ZERO;
		if (rdEn) begin
			if (hitMainTrim) begin
				rdData_nxt = mainRegulatorTrim_r; // RL3
			end else if (hitCoarse) begin
				rdData_nxt = oscCoarseTrimSpread_r; // RL9
			end else begin
				// Fine trim is write-only; unmapped reads give zero
				rdData_nxt = READ_ZERO;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdData_r <= READ_ZERO;
		end else if (clkEn) begin
			rdData_r <= rdData_nxt;
		end
	end

	// ==========================================================
	// Power gating of the analog blocks
	always_comb begin
		mainRegEn_nxt = 1'b1;
		backupRegEn_nxt = 1'b0;
		refEn_nxt = 1'b0;
		oscEn_nxt = 1'b1;
		case (mode)
			PM_NORMAL: begin
				refEn_nxt = 1'b1; // RL5
			end
			PM_STOP: begin
				oscEn_nxt = 1'b0; // RL6
			end
			PM_SLEEP: begin
				mainRegEn_nxt = 1'b0; // RL1
				backupRegEn_nxt = 1'b1; // RL1
			end
			PM_PMM, PM_IDLE: begin
				refEn_nxt = 1'b0; // RL5
			end
			default: begin
				refEn_nxt = 1'b1;
			end
		endcase
	end

	// Enables change only on a clock edge, so the oscillator sees clean
	// levels; its own stop/start is edge-safe by construction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mainRegEn_r <= 1'b1; // RL2
			backupRegEn_r <= 1'b0;
			refEn_r <= 1'b1;
			oscEn_r <= 1'b1;
		end else if (clkEn) begin
			mainRegEn_r <= mainRegEn_nxt; // RL1
			backupRegEn_r <= backupRegEn_nxt; // RL1
			refEn_r <= refEn_nxt; // RL5
			oscEn_r <= oscEn_nxt; // RL6 RL7
		end
	end

	// ==========================================================
	// Sweep generator
	ots_sweep_gen uSweep (
		.clk(clk),
		.rstn(rstn),
		.clkEn(clkEn),
		.sweepRateCode(sweepRateCode), // RL14
		.sweepAmplitudeCode(sweepAmplitudeCode), // RL11
		.sweepOfs(sweepOfs)
	);

	// ==========================================================
	// Oscillator control code
	// Sum is widened so the clamp sees the true overshoot
	assign trimSum = $signed({2'b00, oscFineTrim_r}) + 10'(sweepOfs); // RL12

	always_comb begin
		coarseRange_nxt = coarseRangeField; // RL13
		if (sweepRateCode == RATE_OFF) begin
			modTrim_nxt = oscFineTrim_r; // RL10
		end else if (trimSum < TRIM_CLAMP_MIN) begin
			modTrim_nxt = TRIM_CLAMP_MIN[7:0]; // RL16
		end else if (trimSum > TRIM_CLAMP_MAX) begin
			modTrim_nxt = TRIM_CLAMP_MAX[7:0]; // RL16
		end else begin
			modTrim_nxt = trimSum[7:0]; // RL12 RL15
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			coarseRange_r <= OSC_COARSE_TRIM_SPREAD_RST[RANGE_HI:RANGE_LO]; // RL8
			modTrim_r <= OSC_FINE_TRIM_RST; // RL8
		end else if (clkEn) begin
			coarseRange_r <= coarseRange_nxt; // RL13
			modTrim_r <= modTrim_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign rdData = rdData_r;
	assign mainRegulatorTrim = mainRegulatorTrim_r; // RL4
	assign mainRegEn = mainRegEn_r;
	assign backupRegEn = backupRegEn_r;
	assign refEn = refEn_r;
	assign oscEn = oscEn_r;
	assign coarseRangeCode = coarseRange_r;
	assign modulatedTrimOutput = modTrim_r;

endmodule // ots_analog_ctrl

/* verification/ots_analog_ctrl_properties.sv */
// Port-level checks for the analog control block
`timescale 1ns/1ps
module ots_analog_ctrl_properties
	import ots_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic [2:0] powerMode,
	input wire logic [15:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	input wire logic [7:0] rdData,
	input wire logic [7:0] mainRegulatorTrim,
	input wire logic mainRegEn,
	input wire logic backupRegEn,
	input wire logic refEn,
	input wire logic oscEn,
	input wire logic [1:0] coarseRangeCode,
	input wire logic [7:0] modulatedTrimOutput
);
	// ====================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_reg_reset: assert property ($rose(rstn) |-> mainRegEn)
		else $error("main regulator off after reset");
	chk_sleep_backup: assert property (clkEn && powerMode == PM_SLEEP |=> !mainRegEn && backupRegEn)
		else $error("sleep did not hand over to backup");
	chk_main_awake: assert property (clkEn && powerMode != PM_SLEEP |=> mainRegEn && !backupRegEn)
		else $error("main regulator wrong outside sleep");
	chk_ref_normal: assert property (clkEn |=> refEn == ($past(powerMode) == PM_NORMAL || $past(powerMode) > 3'h4))
		else $error("reference enable wrong");
	chk_osc_stop: assert property (clkEn |=> oscEn == ($past(powerMode) != PM_STOP))
		else $error("oscillator enable wrong");
	chk_trim_write: assert property (clkEn && wrEn && addr == MAIN_REG_TRIM_ADDR |=> mainRegulatorTrim == $past(wrData))
		else $error("regulator trim not written");
	chk_read_idle: assert property (clkEn && !rdEn |=> rdData == READ_ZERO)
		else $error("read data not idle");
	chk_read_trim: assert property (clkEn && rdEn && addr == MAIN_REG_TRIM_ADDR |=> rdData == mainRegulatorTrim)
		else $error("regulator trim read wrong");
	chk_range_follow: assert property (clkEn && wrEn && addr == OSC_COARSE_TRIM_SPREAD_ADDR ##1 clkEn |=> coarseRangeCode == 2'($past(wrData, 2)))
		else $error("coarse range not driven");
	chk_sweep_step: assert property ((clkEn && !wrEn) [*5] |=> 8'(modulatedTrimOutput - $past(modulatedTrimOutput)) inside {8'h00, 8'h01, 8'hff})
		else $error("trim output jumped");
endmodule // ots_analog_ctrl_properties

bind ots_analog_ctrl ots_analog_ctrl_properties chk (.clk, .rstn, .clkEn, .powerMode, .addr, .wrData, .wrEn, .rdEn,
	.rdData, .mainRegulatorTrim, .mainRegEn, .backupRegEn, .refEn, .oscEn, .coarseRangeCode, .modulatedTrimOutput);

/* verification/ots_analog_model.sv */
// Behavioural model of the core supply regulators
`timescale 1ns/1ps
module ots_analog_model #(
	parameter logic [7:0] BACKUP_LEVEL = 8'h10
)
(
	input wire logic mainRegEn,
	input wire logic backupRegEn,
	input wire logic [7:0] mainRegulatorTrim,
	output logic [7:0] coreLevel
);
	// Backup stage is untrimmed; with both off the rail collapses
	assign coreLevel = mainRegEn ? mainRegulatorTrim : (backupRegEn ? BACKUP_LEVEL : 8'h00);
endmodule // ots_analog_model

/* verification/ots_analog_ctrl_tb.sv */
// Self-checking bench for the analog control block
`timescale 1ns/1ps
module ots_analog_ctrl_tb import ots_pkg::*; ();
	logic clk = 0, rstn = 0, clkEn = 1, wrEn = 0, rdEn = 0;
	logic [2:0] powerMode = 0;
	logic [15:0] addr = 0;
	logic [7:0] wrData = 0;
	logic [7:0] rdData, mainRegulatorTrim, modulatedTrimOutput, coreLevel;
	logic mainRegEn, backupRegEn, refEn, oscEn;
	logic [1:0] coarseRangeCode;
	int numErrors = 0, comparisons = 0, cycleCount = 0;
	always #10 clk = ~clk;
	ots_analog_ctrl dut (.clk, .rstn, .clkEn, .powerMode, .addr, .wrData, .wrEn, .rdEn, .rdData,
		.mainRegulatorTrim, .mainRegEn, .backupRegEn, .refEn, .oscEn, .coarseRangeCode, .modulatedTrimOutput);
	ots_analog_model model (.mainRegEn, .backupRegEn, .mainRegulatorTrim, .coreLevel);
	// ====================
	// Helpers
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		addr <= a;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		rdEn <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		#1 chk(rdData, e);
	endtask
	// ====================
	// Scenarios
	task automatic t_reset;
		cyc(1);
		chk(mainRegEn, 1'b1);
		chk(modulatedTrimOutput, OSC_FINE_TRIM_RST);
		chk(coarseRangeCode, 2'h0);
		rd(MAIN_REG_TRIM_ADDR, 8'hff);
		rd(OSC_COARSE_TRIM_SPREAD_ADDR, 8'h00);
		rd(OSC_FINE_TRIM_ADDR, 8'h00);
		rd(16'ha003, 8'h00);
	endtask
	task automatic t_regs;
		wr(MAIN_REG_TRIM_ADDR, 8'h5a);
		wr(16'ha003, 8'h00);
		rd(MAIN_REG_TRIM_ADDR, 8'h5a);
		chk(coreLevel, 8'h5a);
		wr(MAIN_REG_TRIM_ADDR, 8'h00);
		cyc(1);
		chk(mainRegulatorTrim, 8'h00);
		wr(OSC_FINE_TRIM_ADDR, 8'h33);
		wr(OSC_COARSE_TRIM_SPREAD_ADDR, 8'h03);
		cyc(2);
		chk(coarseRangeCode, 2'h3);
		chk(modulatedTrimOutput, 8'h33);
		rd(OSC_COARSE_TRIM_SPREAD_ADDR, 8'h03);
	endtask
	task automatic t_power;
		// Non-zero trim so a dead main regulator shows on the rail
		wr(MAIN_REG_TRIM_ADDR, 8'hc3);
		for (int m = 0; m < 8; m++) begin
			@(posedge clk);
			powerMode <= 3'(m);
			cyc(2);
			chk(mainRegEn, m != 4);
			chk(backupRegEn, m == 4);
			chk(coreLevel, m == 4 ? 8'h10 : 8'hc3);
			chk(refEn, m == 0 || m > 4);
			chk(oscEn, m != 3);
		end
		@(posedge clk);
		powerMode <= 3'h0;
	endtask
	task automatic t_sweep(input logic [7:0] fine, input logic [1:0] amp, input logic [3:0] r);
		int dev, lo, hi, n;
		logic [7:0] prev, mn, mx;
		dev = 4 << amp;
		lo = (fine < dev) ? 0 : fine - dev;
		hi = (fine + dev > 255) ? 255 : fine + dev;
		n = 0;
		wr(OSC_COARSE_TRIM_SPREAD_ADDR, 8'h00);
		wr(OSC_FINE_TRIM_ADDR, fine);
		wr(OSC_COARSE_TRIM_SPREAD_ADDR, {r, amp, 2'h1});
		cyc(8);
		prev = modulatedTrimOutput;
		mn = prev;
		mx = prev;
		repeat (8 * dev * r) begin
			cyc(1);
			if (modulatedTrimOutput !== prev) n++;
			prev = modulatedTrimOutput;
			if (prev < mn) mn = prev;
			if (prev > mx) mx = prev;
		end
		chk(mn, lo[7:0]);
		chk(mx, hi[7:0]);
		if (lo > 0 && hi < 255) chk(n, 8 * dev);
	endtask
	task automatic t_freeze;
		logic [7:0] v;
		@(posedge clk);
		clkEn <= 1'b0;
		#1 v = modulatedTrimOutput;
		repeat (5) begin
			cyc(1);
			chk(modulatedTrimOutput, v);
		end
		@(posedge clk);
		clkEn <= 1'b1;
	endtask
	// ====================
	// Main sequence
	always @(posedge clk) begin
		cycleCount <= cycleCount + 1;
		if (cycleCount == 10000) begin
			numErrors++;
			tally_and_finish;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_regs;
		t_power;
		for (int a = 0; a < 4; a++) t_sweep(8'h80, 2'(a), 4'(a + 1));
		t_sweep(8'h02, AMP_CODE_8, 4'h1);
		t_freeze;
		t_sweep(8'hfc, AMP_CODE_8, 4'hf);
		wr(OSC_COARSE_TRIM_SPREAD_ADDR, 8'h00);
		cyc(3);
		chk(modulatedTrimOutput, 8'hfc);
		wr(OSC_COARSE_TRIM_SPREAD_ADDR, 8'h37);
		wr(MAIN_REG_TRIM_ADDR, 8'h12);
		@(posedge clk);
		rstn <= 1'b0;
		cyc(3);
		@(posedge clk);
		rstn <= 1'b1;
		t_reset;
		tally_and_finish;
	end
endmodule // ots_analog_ctrl_tb
